/* logic/wdg_pkg.sv */
// Package of constants, types and helpers for the digital watchdog.
package wdg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] WDG_CTRL_ADDR = 8'hD8;
  localparam logic [7:0] WDG_CTRL_RESET = 8'hFE;
  localparam int WDG_CTRL_BIT = 0;
  localparam int WDG_SELF_RESET_BIT = 1;
  localparam int WDG_CNT_LO = 2;
  localparam int WDG_CNT_HI = 7;
  localparam int WDG_SELF_RESET_PHYS = 6;
  localparam logic [6:0] WDG_CNT_RESET = 7'h7F;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WDG_DIV_RATIO = 12;
  localparam int WDG_TICKS_PER_STEP = 256;
  localparam int WDG_OSC_PER_STEP = WDG_DIV_RATIO * WDG_TICKS_PER_STEP;

  // ****************************************
  // Types
  // ****************************************
  // Both exits from run flip a single bit
  typedef enum logic [1:0] {
    WDG_RUN = 2'b00,
    WDG_WAIT = 2'b01,
    WDG_STOP = 2'b10
  } wdg_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } wdg_bus_req_t;

  // Register bits 7..2 hold physical counter bits 0..5 in reverse
  function automatic logic [5:0] wdg_rev6(input logic [5:0] v);
    wdg_rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction : wdg_rev6

endpackage : wdg_pkg

/* logic/wdg_watchdog.sv */
// Digital watchdog downcounter with its data-space control register.
`timescale 1ns/1ps

// How it works
// RQ1: Active watchdog raises chip reset when the downcounter runs out.
// RQ2: Software reloads the counter in time; the block just obeys writes.
// RQ3: Two static straps pick activation type and external stop control.
// RQ4: Software activation: watchdog idle until the control bit is written 1.
// RQ5: Once active, no write can deactivate it; only chip reset does.
// RQ6: STOP while inactive enters true low-power stop.
// RQ7: Hardware activation keeps the watchdog active from reset on.
// RQ8: Hardware mode without external control turns STOP into WAIT.
// RQ9: External control with the NMI pin low turns STOP into WAIT.
// RQ10: External control with the NMI pin high freezes counting and stops.
// RQ11: A wake-up interrupt resumes counting from the frozen value.
// RQ12: Register at D8h resets to FEh.
// RQ13: Self-reset bit falling, also by a write of zero, resets at once.
// RQ14: Register bits 7..2 are physical count bits 0..5, reversed.
// RQ15: Reset fires when physical bit 6, the self-reset bit, falls.
// RQ16: Six count bits give 64 periods, 3072 to 196608 clocks.
// RQ17: Hardware activation reads control bit as one and ignores writes.
// RQ18: Inactive, the counter is a free 7-bit timer with no reset.
// RQ19: The timing chain runs from the clock divided by twelve.
// RQ20: Watchdog reset goes through the same path as the reset pin.
// RQ21: One decrement every 256 divided ticks, 3072 clocks.
module wdg_watchdog
  import wdg_pkg::*;
#(
  parameter int DIV_RATIO = WDG_DIV_RATIO,
  parameter int TICKS_PER_STEP = WDG_TICKS_PER_STEP
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire wdg_bus_req_t bus_in,
  input wire logic hw_activation_in,
  input wire logic ext_stop_ctrl_in,
  input wire logic nmi_in,
  input wire logic stop_req_in,
  input wire logic wake_in,
  output logic [7:0] rdata_out,
  output logic chip_reset_out,
  output logic active_out,
  output logic stop_mode_out,
  output logic wait_mode_out
);

  // Every check below runs on this clock and this reset
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ****************************************
  // State
  // ****************************************
  logic [3:0] div_reg, div_next;
  logic [7:0] tick_reg, tick_next;
  logic [6:0] cnt_reg, cnt_next;
  logic ctrl_reg, ctrl_next;
  logic wdrst_reg, wdrst_next;
  logic [7:0] rdata_reg, rdata_next;
  logic active_reg, active_next;
  wdg_mode_t mode_reg, mode_next;
  logic stop_reg, stop_next;
  logic wait_reg, wait_next;

  logic active;
  logic wr_hit;
  logic div_tick;
  logic step;
  logic [7:0] reg_view;

  assign active = hw_activation_in | ctrl_reg; // RQ3 RQ7
  assign wr_hit = bus_in.wr && (bus_in.addr == WDG_CTRL_ADDR);
  assign div_tick = (div_reg == 4'(DIV_RATIO - 1)); // RQ19
  assign step = div_tick && (tick_reg == 8'(TICKS_PER_STEP - 1)); // RQ21
  // Control bit is forced to one under hardware activation
  assign reg_view = {wdg_rev6(cnt_reg[5:0]), cnt_reg[WDG_SELF_RESET_PHYS],
                     active}; // RQ14 RQ17

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    div_next = div_reg;
    tick_next = tick_reg;
    cnt_next = cnt_reg;
    ctrl_next = ctrl_reg;
    wdrst_next = wdrst_reg;
    mode_next = mode_reg;
    rdata_next = (bus_in.rd && bus_in.addr == WDG_CTRL_ADDR) ?
                 reg_view : 8'h00;
    // Oscillator is off in true stop, so the whole chain freezes
    if (mode_reg != WDG_STOP) begin // RQ10 RQ11
      div_next = div_tick ? 4'h0 : div_reg + 4'h1;
      if (div_tick) begin
        // Wrap at the step so shorter step lengths also work
        tick_next = step ? 8'h00 : tick_reg + 8'h01; // RQ21
      end
      if (step) begin
        cnt_next = cnt_reg - 7'h01; // RQ16 RQ18
        // A reload in the same cycle wins over the last decrement
        if (active && !wr_hit && cnt_reg[WDG_SELF_RESET_PHYS] &&
            !cnt_next[WDG_SELF_RESET_PHYS]) begin
          wdrst_next = 1'b1; // RQ1 RQ15
        end
      end
    end
    if (wr_hit) begin // RQ2
      cnt_next = {bus_in.wdata[WDG_SELF_RESET_BIT],
                  wdg_rev6(bus_in.wdata[WDG_CNT_HI:WDG_CNT_LO])}; // RQ14
      // Writing one may set the bit; a zero never clears it
      ctrl_next = ctrl_reg | bus_in.wdata[WDG_CTRL_BIT]; // RQ4 RQ5
      if (cnt_reg[WDG_SELF_RESET_PHYS] &&
          !bus_in.wdata[WDG_SELF_RESET_BIT]) begin
        wdrst_next = 1'b1; // RQ13
      end
    end
    case (mode_reg)
      WDG_RUN: begin
        if (stop_req_in) begin
          if (!active) begin
            mode_next = WDG_STOP; // RQ6
          end else if (ext_stop_ctrl_in && nmi_in) begin
            mode_next = WDG_STOP; // RQ10
          end else begin
            mode_next = WDG_WAIT; // RQ8 RQ9
          end
        end
      end
      WDG_WAIT, WDG_STOP: begin
        if (wake_in) begin
          mode_next = WDG_RUN; // RQ11
        end
      end
      default: mode_next = WDG_RUN;
    endcase
    active_next = hw_activation_in | ctrl_next;
    stop_next = (mode_next == WDG_STOP);
    wait_next = (mode_next == WDG_WAIT);
  end

  // ****************************************
  // Registers
  // ****************************************
  // The reset request is held until the chip reset logic pulls
  // resetn_in; it then gets the same stabilisation delay as the pin.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_reg <= 4'h0;
      tick_reg <= 8'h00;
      cnt_reg <= WDG_CNT_RESET; // RQ12
      ctrl_reg <= 1'b0; // RQ12
      wdrst_reg <= 1'b0; // RQ20
      rdata_reg <= 8'h00;
      active_reg <= 1'b0;
      mode_reg <= WDG_RUN;
      stop_reg <= 1'b0;
      wait_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      cnt_reg <= cnt_next;
      ctrl_reg <= ctrl_next;
      wdrst_reg <= wdrst_next;
      rdata_reg <= rdata_next;
      active_reg <= active_next;
      mode_reg <= mode_next;
      stop_reg <= stop_next;
      wait_reg <= wait_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign chip_reset_out = wdrst_reg;
  assign active_out = active_reg;
  assign stop_mode_out = stop_reg;
  assign wait_mode_out = wait_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_stop_asked;
    mode_reg == WDG_RUN && stop_req_in;
  endsequence

  sequence s_last_step;
    active && step && mode_reg != WDG_STOP && !wr_hit &&
      cnt_reg == 7'h40;
  endsequence

  chk_count_expiry: assert property ( // RQ1
    s_last_step |=> chip_reset_out && cnt_reg == 7'h3F)
    else $error("expiry did not raise chip reset");

  chk_self_reset_write: assert property ( // RQ13
    wr_hit && cnt_reg[WDG_SELF_RESET_PHYS] &&
      !bus_in.wdata[WDG_SELF_RESET_BIT] |=> chip_reset_out)
    else $error("self-reset write ignored");

  chk_hw_active: assert property ( // RQ7
    hw_activation_in |=> active_out)
    else $error("hardware option not active");

  chk_no_deact: assert property ( // RQ5
    active_out |=> active_out [*2])
    else $error("watchdog deactivated");

  chk_sw_idle: assert property ( // RQ4
    !hw_activation_in && !ctrl_reg &&
      !(wr_hit && bus_in.wdata[WDG_CTRL_BIT]) |=> !ctrl_reg)
    else $error("activated without a write");

  chk_timer_free: assert property ( // RQ18
    !active && !wr_hit && !chip_reset_out |=> !chip_reset_out)
    else $error("inactive timer caused reset");

  chk_stop_true: assert property ( // RQ6
    s_stop_asked ##0 !active |=> stop_mode_out && !wait_mode_out)
    else $error("inactive stop not taken");

  chk_stop_wait: assert property ( // RQ8 RQ9
    s_stop_asked ##0 active && (!ext_stop_ctrl_in || !nmi_in)
      |=> wait_mode_out ##1 $changed(div_reg))
    else $error("stop not turned into wait");

  chk_stop_freeze: assert property ( // RQ10
    mode_reg == WDG_STOP && !wr_hit |=> $stable(cnt_reg) && $stable(div_reg))
    else $error("counter moved in stop");

  chk_wake_resume: assert property ( // RQ11
    mode_reg == WDG_STOP && wake_in |=> !stop_mode_out ##1 $changed(div_reg))
    else $error("no resume after wake");

  chk_read_map: assert property ( // RQ14
    bus_in.rd && bus_in.addr == WDG_CTRL_ADDR
      |=> rdata_out == {wdg_rev6($past(cnt_reg[5:0])),
                        $past(cnt_reg[6]), $past(active)})
    else $error("register read mapping wrong");

endmodule : wdg_watchdog

/* tb/wdg_reset_model.sv */
// Chip reset logic model that sits beside the watchdog.
`timescale 1ns/1ps
module wdg_reset_model #(
  parameter int HOLD = 4
) (
  input wire logic clk_in,
  input wire logic pin_resetn_in,
  input wire logic chip_reset_in,
  output logic resetn_out
);
  int cnt = 0;
  initial resetn_out = 1'b0;
  // Watchdog reset is stretched like the pin, as a stabilisation delay
  always @(posedge clk_in or negedge pin_resetn_in) begin
    if (!pin_resetn_in || chip_reset_in) begin
      cnt <= HOLD;
      resetn_out <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      resetn_out <= 1'b1;
    end
  end
endmodule : wdg_reset_model

/* tb/wdg_watchdog_bench.sv */
// Self-checking bench for the digital watchdog downcounter.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  err_total++; $display("wrong value at %0t: got %h", $time, got); end end
module wdg_watchdog_bench;
  import wdg_pkg::*;
  logic clk_in = 1'b0;
  logic pin_n = 1'b0;
  logic resetn_in, hw = 1'b0, ext = 1'b0, nmi = 1'b0;
  logic stop = 1'b0, wake = 1'b0, seen;
  wdg_bus_req_t bus = '0;
  logic [7:0] rdata_out, r1, r2;
  logic chip_reset_out, active_out, stop_mode_out, wait_mode_out;
  int err_total = 0, total_checks = 0;
  always #50 clk_in = ~clk_in;
  // Short prescaler so one decrement takes 4 clocks
  wdg_watchdog #(.DIV_RATIO(2), .TICKS_PER_STEP(2)) DUT (.clk_in(clk_in),
    .resetn_in(resetn_in), .bus_in(bus), .hw_activation_in(hw),
    .ext_stop_ctrl_in(ext), .nmi_in(nmi), .stop_req_in(stop),
    .wake_in(wake), .rdata_out(rdata_out), .chip_reset_out(chip_reset_out),
    .active_out(active_out), .stop_mode_out(stop_mode_out),
    .wait_mode_out(wait_mode_out));
  wdg_reset_model #(.HOLD(4)) rst_model (.clk_in(clk_in),
    .pin_resetn_in(pin_n), .chip_reset_in(chip_reset_out),
    .resetn_out(resetn_in));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    bus = '{addr: a, wr: w, rd: !w, wdata: d};
    tick(1);
    bus = '0;
    q = rdata_out;
  endtask : acc
  task automatic pulse(input logic s);
    if (s) begin
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
    end else begin
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
    end
  endtask : pulse
  // Chip reset reaches resetn_in one clock after the request
  task automatic settle();
    int n;
    n = 0;
    while (resetn_in !== 1'b0 && n < 50) begin
      tick(1);
      n++;
    end
    while (resetn_in !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    if (n == 50) begin
      err_total++;
      results();
    end
  endtask : settle
  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (chip_reset_out !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      err_total++;
      results();
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    settle();
  endtask : wait_rst
  task automatic rst_with(input logic h, input logic e);
    hw = h;
    ext = e;
    pin_n = 1'b0;
    tick(6);
    pin_n = 1'b1;
    settle();
    // The active flag follows the strap one clock after release
    tick(1);
  endtask : rst_with
  initial begin
    rst_with(1'b0, 1'b0);
    acc(1'b0, WDG_CTRL_ADDR, 8'h00, r1);
    tick(1);
    `CHK(r1, WDG_CTRL_RESET)
    acc(1'b0, 8'hD9, 8'h00, r1);
    `CHK(r1, 8'h00)
    `CHK(active_out, 1'b0)
    pulse(1'b1);
    `CHK(stop_mode_out, 1'b1)
    pulse(1'b0);
    seen = 1'b0;
    repeat (600) begin
      tick(1);
      seen = seen | chip_reset_out;
    end
    `CHK(seen, 1'b0)
    acc(1'b1, WDG_CTRL_ADDR, 8'hC3, r1);
    tick(1);
    acc(1'b1, WDG_CTRL_ADDR, 8'hC2, r1);
    // Reload every nine clocks, well inside the sixteen-clock expiry
    repeat (8) begin
      repeat (8) begin
        tick(1);
        seen = seen | chip_reset_out;
      end
      acc(1'b1, WDG_CTRL_ADDR, 8'hC2, r1);
    end
    `CHK(seen, 1'b0)
    `CHK(active_out, 1'b1)
    wait_rst(12, 18);
    `CHK(active_out, 1'b0)
    acc(1'b1, WDG_CTRL_ADDR, 8'hFC, r1);
    `CHK(chip_reset_out, 1'b1)
    settle();
    rst_with(1'b1, 1'b0);
    `CHK(active_out, 1'b1)
    acc(1'b1, WDG_CTRL_ADDR, 8'hFE, r1);
    tick(1);
    acc(1'b0, WDG_CTRL_ADDR, 8'h00, r1);
    `CHK(r1 & 8'h03, 8'h03)
    pulse(1'b1);
    `CHK({wait_mode_out, stop_mode_out}, 2'b10)
    pulse(1'b0);
    rst_with(1'b1, 1'b1);
    pulse(1'b1);
    `CHK({wait_mode_out, stop_mode_out}, 2'b10)
    pulse(1'b0);
    nmi = 1'b1;
    acc(1'b1, WDG_CTRL_ADDR, 8'hFF, r1);
    pulse(1'b1);
    `CHK(stop_mode_out, 1'b1)
    acc(1'b0, WDG_CTRL_ADDR, 8'h00, r1);
    tick(20);
    acc(1'b0, WDG_CTRL_ADDR, 8'h00, r2);
    `CHK(r2, r1)
    pulse(1'b0);
    tick(20);
    acc(1'b0, WDG_CTRL_ADDR, 8'h00, r2);
    `CHK(r2 !== r1, 1'b1)
    results();
  end
endmodule : wdg_watchdog_bench
